/* File: logic/pmrs_consts.svh */
// Constants for the power mode and reset sequencer
`ifndef PMRS_CONSTS_SVH
`define PMRS_CONSTS_SVH

`define PMRS_CLK_HZ 10000000
`define PMRS_RC_HZ 4000000
`define PMRS_TMR_W 16
`define PMRS_TICK_W 13
`define PMRS_RC_START_NS 60000
`define PMRS_RC_START_CYC ((`PMRS_RC_START_NS * (`PMRS_CLK_HZ / 1000000) + 999) / 1000)
`define PMRS_FLASH_WAKE_NS 100000
`define PMRS_FLASH_WAKE_TICKS ((`PMRS_FLASH_WAKE_NS * (`PMRS_RC_HZ / 1000000) + 999) / 1000)
`define PMRS_WAKE_RC_TICKS 4
`define PMRS_WAKE_OSC_TICKS 4096
`define PMRS_RST_TICKS 16
`define PMRS_BOOT_VECTOR 32'h0000_0000
`define PMRS_CTL_RST 10'h0FB
`define PMRS_EINT_N 4

`endif

/* File: logic/pmrs_pkg.sv */
// Types for the power mode and reset sequencer
package pmrs_pkg;

    typedef enum logic [2:0] {
        PMRS_RESET,
        PMRS_RUN,
        PMRS_IDLE,
        PMRS_SLEEP,
        PMRS_PDOWN,
        PMRS_DPD,
        PMRS_WAKE_START,
        PMRS_WAKE_COUNT
    } pmrs_mode_t;

    // Asynchronous inputs, all passed through the synchroniser
    typedef struct packed {
        logic rst_pin_n;
        logic wdt_rst;
        logic por_det;
        logic brownout_stage1;
        logic brownout_stage2;
        logic osc_running;
        logic rtc_alarm;
        logic rtc_wake_irq;
        logic [3:0] ext_int;
    } pmrs_pins_t;

    // Power and clock controls towards the chip
    typedef struct packed {
        logic cpu_run_en;
        logic periph_clk_en;
        logic main_osc_en;
        logic rc_out_en;
        logic rc_power_en;
        logic rtc_osc_en;
        logic flash_power_en;
        logic pin_hold;
        logic regulator_en;
        logic chip_rst;
    } pmrs_ctl_t;

endpackage

/* File: logic/pmrs_sync.sv */
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module pmrs_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    meta_reg[i] <= 1'b0;
                    q_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= d_in[i];
                    q_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule

/* File: logic/pmrs_timer.sv */
// Loadable down-counter that steps on an enable pulse
`timescale 1ns/1ps
`include "pmrs_consts.svh"
module pmrs_timer (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [`PMRS_TMR_W-1:0] load_val,
    input wire logic tick,
    output logic done
);
    logic [`PMRS_TMR_W-1:0] cnt_reg;
    logic [`PMRS_TMR_W-1:0] cnt_next;

    assign done = (cnt_reg == '0);
    assign cnt_next = load ? load_val : ((tick && !done) ? cnt_reg - 1'b1 : cnt_reg);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

/* File: logic/pmrs_top.sv */
// Power mode and reset sequencer: low-power modes, wake timing, reset release
`timescale 1ns/1ps
`include "pmrs_consts.svh"
module pmrs_top (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire pmrs_pkg::pmrs_pins_t pins,
    input wire logic rc_tick,
    input wire logic osc_tick,
    input wire logic src_main_osc,
    input wire logic cpu_irq,
    input wire logic req_idle,
    input wire logic req_sleep,
    input wire logic req_pdown,
    input wire logic req_dpd,
    input wire logic [`PMRS_EINT_N-1:0] ext_wake_en,
    input wire logic flash_init_done,
    output pmrs_pkg::pmrs_ctl_t ctl,
    output logic pll_off_pulse,
    output logic div_clear_pulse,
    output logic flash_access_en,
    output logic brownout_irq,
    output logic brownout_status,
    output logic [31:0] fetch_addr,
    output pmrs_pkg::pmrs_mode_t mode
);
    localparam logic [`PMRS_TMR_W-1:0] RST_LOAD = `PMRS_TMR_W'(`PMRS_RST_TICKS);
    localparam logic [`PMRS_TMR_W-1:0] START_LOAD = `PMRS_TMR_W'(`PMRS_RC_START_CYC);
    localparam logic [`PMRS_TMR_W-1:0] RC_LOAD = `PMRS_TMR_W'(`PMRS_WAKE_RC_TICKS);
    localparam logic [`PMRS_TMR_W-1:0] OSC_LOAD = `PMRS_TMR_W'(`PMRS_WAKE_OSC_TICKS);
    localparam logic [`PMRS_TMR_W-1:0] FLASH_LOAD = `PMRS_TMR_W'(`PMRS_FLASH_WAKE_TICKS);

    // ****************************************
    // Input synchronisation
    // ****************************************
    pmrs_pkg::pmrs_pins_t pin_s;
    logic [$bits(pmrs_pkg::pmrs_pins_t)-1:0] pin_vec;

    pmrs_sync #(
        .W($bits(pmrs_pkg::pmrs_pins_t))
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d_in(pins),
        .q_out(pin_vec)
    );
    assign pin_s = pmrs_pkg::pmrs_pins_t'(pin_vec);

    // ****************************************
    // Reset sources and wake qualification
    // ****************************************
    wire reset_req = !pin_s.rst_pin_n || pin_s.wdt_rst || pin_s.por_det || pin_s.brownout_stage2;
    wire ext_wake = |(pin_s.ext_int & ext_wake_en);
    wire clockless_wake = pin_s.rtc_wake_irq || pin_s.rtc_alarm;
    wire sleep_wake = clockless_wake || ext_wake;
    wire pdown_wake = clockless_wake || ext_wake;
    wire dpd_wake = pin_s.rtc_alarm;

    pmrs_pkg::pmrs_mode_t state_reg;
    pmrs_pkg::pmrs_mode_t state_next;
    logic src_main_reg;
    logic tmr_done;
    logic flash_done;
    logic flash_wait_reg;

    // Release waits on all reset sources clear, oscillator, count and flash init together
    wire rst_release = !reset_req && pin_s.osc_running && tmr_done && flash_init_done;

    // ****************************************
    // Mode state machine
    // ****************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pmrs_pkg::PMRS_RESET: begin
                if (rst_release) begin
                    state_next = pmrs_pkg::PMRS_RUN;
                end
            end
            pmrs_pkg::PMRS_RUN: begin
                if (req_dpd) begin
                    state_next = pmrs_pkg::PMRS_DPD;
                end else if (req_pdown) begin
                    state_next = pmrs_pkg::PMRS_PDOWN;
                end else if (req_sleep) begin
                    state_next = pmrs_pkg::PMRS_SLEEP;
                end else if (req_idle) begin
                    state_next = pmrs_pkg::PMRS_IDLE;
                end
            end
            pmrs_pkg::PMRS_IDLE: begin
                if (cpu_irq) begin
                    state_next = pmrs_pkg::PMRS_RUN;
                end
            end
            pmrs_pkg::PMRS_SLEEP: begin
                if (sleep_wake) begin
                    state_next = pmrs_pkg::PMRS_WAKE_COUNT;
                end
            end
            pmrs_pkg::PMRS_PDOWN: begin
                if (pdown_wake) begin
                    // The main oscillator needs no RC start-up wait
                    state_next = src_main_reg ? pmrs_pkg::PMRS_WAKE_COUNT : pmrs_pkg::PMRS_WAKE_START;
                end
            end
            pmrs_pkg::PMRS_DPD: begin
                if (dpd_wake) begin
                    state_next = pmrs_pkg::PMRS_RESET;
                end
            end
            pmrs_pkg::PMRS_WAKE_START: begin
                if (tmr_done) begin
                    state_next = pmrs_pkg::PMRS_WAKE_COUNT;
                end
            end
            pmrs_pkg::PMRS_WAKE_COUNT: begin
                if (tmr_done) begin
                    state_next = pmrs_pkg::PMRS_RUN;
                end
            end
            default: begin
                state_next = pmrs_pkg::PMRS_RESET;
            end
        endcase
        if (reset_req) begin
            state_next = pmrs_pkg::PMRS_RESET;
        end
    end

    // ****************************************
    // Wake and reset timer
    // ****************************************
    wire entering = (state_next != state_reg);
    wire tmr_load = (entering || (state_next == pmrs_pkg::PMRS_RESET && reset_req)) &&
                    (state_next == pmrs_pkg::PMRS_RESET || state_next == pmrs_pkg::PMRS_WAKE_START ||
                     state_next == pmrs_pkg::PMRS_WAKE_COUNT);
    wire [`PMRS_TMR_W-1:0] tmr_val = (state_next == pmrs_pkg::PMRS_RESET) ? RST_LOAD :
                                     (state_next == pmrs_pkg::PMRS_WAKE_START) ? START_LOAD :
                                     (src_main_reg ? OSC_LOAD : RC_LOAD);
    // Start-up wait counts system cycles; main oscillator wake counts osc_tick, other waits count rc_tick
    wire tmr_tick = (state_reg == pmrs_pkg::PMRS_WAKE_START) ? 1'b1 :
                    (state_reg == pmrs_pkg::PMRS_WAKE_COUNT && src_main_reg) ? osc_tick : rc_tick;

    pmrs_timer u_wake_tmr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .tick(tmr_tick),
        .done(tmr_done)
    );

    // ****************************************
    // Flash wake-up timer
    // ****************************************
    wire flash_load = (state_reg == pmrs_pkg::PMRS_PDOWN) && entering;

    pmrs_timer u_flash_tmr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .load(flash_load),
        .load_val(FLASH_LOAD),
        .tick(rc_tick),
        .done(flash_done)
    );

    // ****************************************
    // Control decode
    // ****************************************
    function automatic pmrs_pkg::pmrs_ctl_t ctl_of(input pmrs_pkg::pmrs_mode_t m);
        pmrs_pkg::pmrs_ctl_t c;
        logic low;
        logic deep;
        low = (m == pmrs_pkg::PMRS_SLEEP) || (m == pmrs_pkg::PMRS_PDOWN) || (m == pmrs_pkg::PMRS_DPD);
        deep = (m == pmrs_pkg::PMRS_PDOWN) || (m == pmrs_pkg::PMRS_DPD);
        c.cpu_run_en = (m == pmrs_pkg::PMRS_RUN);
        c.periph_clk_en = (m == pmrs_pkg::PMRS_RUN) || (m == pmrs_pkg::PMRS_IDLE);
        c.main_osc_en = !low && (m != pmrs_pkg::PMRS_WAKE_START);
        c.rc_out_en = !low && (m != pmrs_pkg::PMRS_WAKE_START);
        c.rc_power_en = !deep;
        c.rtc_osc_en = 1'b1;
        c.flash_power_en = !deep;
        c.pin_hold = (m == pmrs_pkg::PMRS_SLEEP) || (m == pmrs_pkg::PMRS_PDOWN);
        c.regulator_en = (m != pmrs_pkg::PMRS_DPD);
        c.chip_rst = (m == pmrs_pkg::PMRS_RESET) || (m == pmrs_pkg::PMRS_DPD);
        return c;
    endfunction

    wire pmrs_pkg::pmrs_ctl_t ctl_next = ctl_of(state_next);
    wire low_entry = entering && (state_next == pmrs_pkg::PMRS_SLEEP || state_next == pmrs_pkg::PMRS_PDOWN ||
                                  state_next == pmrs_pkg::PMRS_DPD);

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= pmrs_pkg::PMRS_RESET;
            ctl <= pmrs_pkg::pmrs_ctl_t'(`PMRS_CTL_RST);
            src_main_reg <= 1'b0;
            pll_off_pulse <= 1'b0;
            div_clear_pulse <= 1'b0;
            flash_wait_reg <= 1'b0;
            brownout_irq <= 1'b0;
            brownout_status <= 1'b0;
            fetch_addr <= `PMRS_BOOT_VECTOR;
        end else begin
            state_reg <= state_next;
            ctl <= ctl_next;
            // Processor state stays in place; only reset changes it
            if (state_reg == pmrs_pkg::PMRS_RUN && low_entry) begin
                src_main_reg <= src_main_osc;
            end else if (state_next == pmrs_pkg::PMRS_RESET) begin
                src_main_reg <= 1'b0;
            end
            pll_off_pulse <= low_entry;
            div_clear_pulse <= low_entry;
            if (flash_load) begin
                flash_wait_reg <= 1'b1;
            end else if (flash_done || state_next == pmrs_pkg::PMRS_RESET) begin
                flash_wait_reg <= 1'b0;
            end
            brownout_irq <= pin_s.brownout_stage1;
            brownout_status <= pin_s.brownout_stage1;
            if (state_next == pmrs_pkg::PMRS_RESET) begin
                fetch_addr <= `PMRS_BOOT_VECTOR;
            end
        end
    end

    assign mode = state_reg;
    assign flash_access_en = !flash_wait_reg && ctl.flash_power_en && !ctl.chip_rst;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic [`PMRS_TICK_W-1:0] tick_seen_reg;
    logic [`PMRS_TMR_W-1:0] dwell_reg;
    logic [`PMRS_TMR_W-1:0] flash_ticks_reg;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tick_seen_reg <= '0;
            dwell_reg <= '0;
            flash_ticks_reg <= '0;
        end else begin
            tick_seen_reg <= (state_reg != pmrs_pkg::PMRS_WAKE_COUNT) ? '0 : tick_seen_reg + `PMRS_TICK_W'(tmr_tick);
            dwell_reg <= entering ? '0 : dwell_reg + 1'b1;
            flash_ticks_reg <= flash_load ? '0 : flash_ticks_reg + `PMRS_TMR_W'(rc_tick && flash_wait_reg);
        end
    end

    property p_idle_halt;
        state_reg == pmrs_pkg::PMRS_IDLE |-> !ctl.cpu_run_en && ctl.periph_clk_en;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("idle clocks wrong");

    property p_idle_wake;
        state_reg == pmrs_pkg::PMRS_IDLE && cpu_irq && !reset_req |=> state_reg == pmrs_pkg::PMRS_RUN;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle did not resume");

    property p_sleep_clk;
        state_reg == pmrs_pkg::PMRS_SLEEP |-> !ctl.main_osc_en && !ctl.rc_out_en && ctl.rc_power_en &&
            ctl.flash_power_en && ctl.rtc_osc_en && ctl.pin_hold;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("sleep controls wrong");

    property p_sleep_entry;
        state_reg == pmrs_pkg::PMRS_RUN && req_sleep && !req_pdown && !req_dpd && !reset_req
            |=> state_reg == pmrs_pkg::PMRS_SLEEP && pll_off_pulse && div_clear_pulse ##1 !pll_off_pulse;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry pulses wrong");

    property p_rc_wake;
        state_reg == pmrs_pkg::PMRS_WAKE_COUNT && state_next == pmrs_pkg::PMRS_RUN && !src_main_reg
            |-> tick_seen_reg == `PMRS_TICK_W'(`PMRS_WAKE_RC_TICKS);
    endproperty
    a_rc_wake: assert property (p_rc_wake) else $error("rc wake count wrong");

    property p_osc_wake;
        state_reg == pmrs_pkg::PMRS_WAKE_COUNT && state_next == pmrs_pkg::PMRS_RUN && src_main_reg
            |-> tick_seen_reg == `PMRS_TICK_W'(`PMRS_WAKE_OSC_TICKS);
    endproperty
    a_osc_wake: assert property (p_osc_wake) else $error("oscillator wake count wrong");

    property p_pdown_off;
        state_reg == pmrs_pkg::PMRS_PDOWN |-> !ctl.rc_power_en && !ctl.flash_power_en && !flash_access_en;
    endproperty
    a_pdown_off: assert property (p_pdown_off) else $error("power-down left supplies on");

    property p_rc_start;
        state_reg == pmrs_pkg::PMRS_WAKE_START && state_next == pmrs_pkg::PMRS_WAKE_COUNT
            |-> dwell_reg == `PMRS_TMR_W'(`PMRS_RC_START_CYC);
    endproperty
    a_rc_start: assert property (p_rc_start) else $error("rc start-up wait wrong");

    property p_flash_gate;
        $fell(flash_wait_reg) && !ctl.chip_rst |-> flash_ticks_reg == FLASH_LOAD;
    endproperty
    a_flash_gate: assert property (p_flash_gate) else $error("flash released early");

    property p_dpd_stay;
        state_reg == pmrs_pkg::PMRS_DPD && !dpd_wake && !reset_req |=> state_reg == pmrs_pkg::PMRS_DPD;
    endproperty
    a_dpd_stay: assert property (p_dpd_stay) else $error("deep power-down left without cause");

    property p_rst_src;
        reset_req |=> ctl.chip_rst && state_reg == pmrs_pkg::PMRS_RESET;
    endproperty
    a_rst_src: assert property (p_rst_src) else $error("reset source ignored");

    property p_rst_release;
        $fell(ctl.chip_rst) |-> $past(rst_release) && fetch_addr == `PMRS_BOOT_VECTOR;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("reset released too early");

    property p_brownout1;
        pin_s.brownout_stage1 |=> brownout_irq && brownout_status;
    endproperty
    a_brownout1: assert property (p_brownout1) else $error("brownout status missing");

    c_sleep_rc: cover property (state_reg == pmrs_pkg::PMRS_WAKE_COUNT ##1 state_reg == pmrs_pkg::PMRS_RUN);
    c_pdown_wake: cover property (state_reg == pmrs_pkg::PMRS_WAKE_START ##1 state_reg == pmrs_pkg::PMRS_WAKE_COUNT);
    c_flash_ready: cover property ($fell(flash_wait_reg));
    c_dpd_exit: cover property (state_reg == pmrs_pkg::PMRS_DPD ##1 state_reg == pmrs_pkg::PMRS_RESET);
endmodule

/* File: tb/pmrs_partner.sv */
// Clock source model: internal RC and main oscillator tick pulses
`timescale 1ns/1ps
module pmrs_partner (
    input wire logic clk_sys,
    output logic rc_tick,
    output logic osc_tick
);
    // ************************************************************
    // Oscillator ticks
    // ************************************************************
    // 4 MHz against 10 MHz: ticks 2 then 3 cycles apart, never back to back
    logic [2:0] phase_reg;
    initial begin
        rc_tick = 1'b0;
        osc_tick = 1'b0;
        phase_reg = 3'h0;
    end
    // Oscillators run free, reset does not stop them
    always @(negedge clk_sys) begin
        phase_reg <= (phase_reg == 3'h4) ? 3'h0 : phase_reg + 3'h1;
        rc_tick <= (phase_reg == 3'h4) || (phase_reg == 3'h1);
        osc_tick <= ~osc_tick;
    end
endmodule

/* File: tb/power_mode_reset_sequencer_bench.sv */
// Self-checking bench for the power mode and reset sequencer
`timescale 1ns/1ps
`include "pmrs_consts.svh"
module power_mode_reset_sequencer_bench;
    logic clk_sys;
    logic sys_rst;
    pmrs_pkg::pmrs_pins_t pins;
    logic rc_tick, osc_tick, src_main_osc, cpu_irq, flash_init_done;
    logic req_idle, req_sleep, req_pdown, req_dpd;
    logic [`PMRS_EINT_N-1:0] ext_wake_en;
    pmrs_pkg::pmrs_ctl_t ctl;
    logic pll_off_pulse, div_clear_pulse, flash_access_en, brownout_irq, brownout_status;
    logic [31:0] fetch_addr;
    logic [31:0] rnd;
    logic fl_on;
    pmrs_pkg::pmrs_mode_t mode, last_mode;
    pmrs_pkg::pmrs_mode_t exp_q[$];
    int mismatches, samples_checked, cyc, wc_rc, wc_osc, ws_cyc, fl_ticks;

    pmrs_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins), .rc_tick(rc_tick), .osc_tick(osc_tick),
        .src_main_osc(src_main_osc), .cpu_irq(cpu_irq), .req_idle(req_idle), .req_sleep(req_sleep),
        .req_pdown(req_pdown), .req_dpd(req_dpd), .ext_wake_en(ext_wake_en), .flash_init_done(flash_init_done),
        .ctl(ctl), .pll_off_pulse(pll_off_pulse), .div_clear_pulse(div_clear_pulse),
        .flash_access_en(flash_access_en), .brownout_irq(brownout_irq), .brownout_status(brownout_status),
        .fetch_addr(fetch_addr), .mode(mode));
    pmrs_partner i_partner (.clk_sys(clk_sys), .rc_tick(rc_tick), .osc_tick(osc_tick));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wait_mode(input pmrs_pkg::pmrs_mode_t m, input int limit);
        int i;
        i = 0;
        while (mode !== m && i < limit) begin
            @(negedge clk_sys);
            i++;
        end
        chk("mode reached", 32'(m), 32'(mode));
    endtask
    // Request held for one edge only; the edge after it must show the pulses, or none for idle
    task automatic request(input int which, input pmrs_pkg::pmrs_mode_t m);
        @(negedge clk_sys);
        {req_dpd, req_pdown, req_sleep, req_idle} = 4'h1 << which;
        exp_q.push_back(m);
        @(negedge clk_sys);
        {req_dpd, req_pdown, req_sleep, req_idle} = 4'h0;
        chk("entry pulses", (which >= 1) ? 32'h3 : 32'h0, 32'({pll_off_pulse, div_clear_pulse}));
    endtask

    // ************************************************************
    // Monitors
    // ************************************************************
    // Every mode change takes the oldest expected mode off the queue
    always @(negedge clk_sys) begin
        if (sys_rst) begin
            last_mode = pmrs_pkg::PMRS_RESET;
        end else if (mode !== last_mode) begin
            last_mode = mode;
            if (exp_q.size() == 0) begin
                chk("unexpected mode change", 32'hFF, 32'(mode));
            end else begin
                chk("mode order", 32'(exp_q.pop_front()), 32'(mode));
            end
        end
    end
    // Sampled before the edge updates land, so counts see the old mode
    always @(posedge clk_sys) begin
        cyc++;
        if (mode === pmrs_pkg::PMRS_WAKE_COUNT && rc_tick) wc_rc++;
        if (mode === pmrs_pkg::PMRS_WAKE_COUNT && osc_tick) wc_osc++;
        if (mode === pmrs_pkg::PMRS_WAKE_START) ws_cyc++;
        if (fl_on && mode !== pmrs_pkg::PMRS_PDOWN && flash_access_en === 1'b0 && rc_tick) fl_ticks++;
        if (cyc == 50000) begin
            mismatches++;
            stop_test();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        pins = '0;
        pins.rst_pin_n = 1'b1;
        {src_main_osc, cpu_irq, flash_init_done, req_idle, req_sleep, req_pdown, req_dpd} = 7'h00;
        ext_wake_en = '0;
        rnd = 32'hEB70;
        fl_on = 1'b0;
        {mismatches, samples_checked, cyc, wc_rc, wc_osc, ws_cyc, fl_ticks} = '0;
        cycles(4);
        sys_rst = 1'b0;
        exp_q.push_back(pmrs_pkg::PMRS_RUN);
        cycles(80);
        chk("reset without osc", 32'h3, 32'({mode == pmrs_pkg::PMRS_RESET, ctl.chip_rst}));
        pins.osc_running = 1'b1;
        cycles(80);
        chk("reset without flash", 32'h3, 32'({mode == pmrs_pkg::PMRS_RESET, ctl.chip_rst}));
        flash_init_done = 1'b1;
        wait_mode(pmrs_pkg::PMRS_RUN, 200);
        chk("fetch address", `PMRS_BOOT_VECTOR, fetch_addr);
        chk("run ctl", 32'h6, 32'({ctl.cpu_run_en, ctl.periph_clk_en, ctl.chip_rst}));
        $display("test reset release done");
        request(0, pmrs_pkg::PMRS_IDLE);
        exp_q.push_back(pmrs_pkg::PMRS_RUN);
        chk("idle ctl", 32'h1, 32'({ctl.cpu_run_en, ctl.periph_clk_en}));
        req_sleep = 1'b1;
        cycles(2 + int'(rnd[3:0]));
        req_sleep = 1'b0;
        chk("request outside run", 32'(pmrs_pkg::PMRS_IDLE), 32'(mode));
        cpu_irq = 1'b1;
        wait_mode(pmrs_pkg::PMRS_RUN, 4);
        cpu_irq = 1'b0;
        $display("test idle done");
        for (int s = 0; s < 2; s++) begin
            src_main_osc = s[0];
            request(1, pmrs_pkg::PMRS_SLEEP);
            chk("sleep ctl", 32'h03E, 32'(ctl));
            rnd = lfsr(rnd);
            ext_wake_en = '0;
            pins.ext_int = 4'hF;
            cycles(10);
            chk("masked wake", 32'(pmrs_pkg::PMRS_SLEEP), 32'(mode));
            pins.ext_int = '0;
            // Let the synchronised pins drain so the intended source wakes
            cycles(3);
            exp_q.push_back(pmrs_pkg::PMRS_WAKE_COUNT);
            exp_q.push_back(pmrs_pkg::PMRS_RUN);
            {wc_rc, wc_osc} = '0;
            ext_wake_en = 4'h1 << rnd[1:0];
            pins.rtc_wake_irq = (s == 0);
            pins.ext_int = (s == 0) ? 4'h0 : 4'hF;
            wait_mode(pmrs_pkg::PMRS_WAKE_COUNT, 6);
            pins.rtc_wake_irq = 1'b0;
            pins.ext_int = '0;
            wait_mode(pmrs_pkg::PMRS_RUN, 9000);
            chk("sleep wake ticks", (s == 0) ? 32'd4 : 32'd4096, 32'((s == 0) ? wc_rc : wc_osc));
        end
        $display("test sleep done");
        for (int s = 0; s < 2; s++) begin
            src_main_osc = s[0];
            request(2, pmrs_pkg::PMRS_PDOWN);
            chk("pdown ctl", 32'h02C, 32'({ctl, flash_access_en}));
            if (s == 0) exp_q.push_back(pmrs_pkg::PMRS_WAKE_START);
            exp_q.push_back(pmrs_pkg::PMRS_WAKE_COUNT);
            exp_q.push_back(pmrs_pkg::PMRS_RUN);
            {wc_rc, wc_osc, ws_cyc, fl_ticks} = '0;
            fl_on = 1'b1;
            rnd = lfsr(rnd);
            ext_wake_en = 4'h1 << rnd[1:0];
            pins.ext_int = ext_wake_en;
            wait_mode((s == 0) ? pmrs_pkg::PMRS_WAKE_START : pmrs_pkg::PMRS_WAKE_COUNT, 6);
            pins.ext_int = '0;
            wait_mode(pmrs_pkg::PMRS_RUN, 9000);
            chk("start cycles", (s == 0) ? 32'd601 : 32'd0, 32'(ws_cyc));
            chk("pdown wake ticks", (s == 0) ? 32'd4 : 32'd4096, 32'((s == 0) ? wc_rc : wc_osc));
            if (s == 0) chk("flash at run", 32'h0, 32'(flash_access_en));
            for (int i = 0; i < 1500 && flash_access_en !== 1'b1; i++) @(negedge clk_sys);
            fl_on = 1'b0;
            chk("flash wake ticks", 32'd400, 32'(fl_ticks));
        end
        $display("test power-down done");
        request(3, pmrs_pkg::PMRS_DPD);
        chk("dpd ctl", 32'h1, 32'({ctl.regulator_en, ctl.chip_rst}));
        pins.rtc_wake_irq = 1'b1;
        pins.ext_int = 4'hF;
        ext_wake_en = 4'hF;
        cycles(10);
        chk("dpd other wake", 32'(pmrs_pkg::PMRS_DPD), 32'(mode));
        {pins.rtc_wake_irq, pins.ext_int} = '0;
        exp_q.push_back(pmrs_pkg::PMRS_RESET);
        exp_q.push_back(pmrs_pkg::PMRS_RUN);
        pins.rtc_alarm = 1'b1;
        wait_mode(pmrs_pkg::PMRS_RESET, 6);
        pins.rtc_alarm = 1'b0;
        wait_mode(pmrs_pkg::PMRS_RUN, 200);
        $display("test deep power-down done");
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back(pmrs_pkg::PMRS_RESET);
            exp_q.push_back(pmrs_pkg::PMRS_RUN);
            pins.rst_pin_n = (k != 0);
            pins.wdt_rst = (k == 1);
            pins.por_det = (k == 2);
            pins.brownout_stage2 = (k == 3);
            wait_mode(pmrs_pkg::PMRS_RESET, 6);
            cycles(60);
            chk("source held", 32'h3, 32'({mode == pmrs_pkg::PMRS_RESET, ctl.chip_rst}));
            {pins.rst_pin_n, pins.wdt_rst, pins.por_det, pins.brownout_stage2} = 4'h8;
            wait_mode(pmrs_pkg::PMRS_RUN, 200);
        end
        $display("test reset sources done");
        pins.brownout_stage1 = 1'b1;
        cycles(2);
        chk("brownout early", 32'h0, 32'({brownout_irq, brownout_status}));
        cycles(1);
        chk("brownout flag", 32'h3, 32'({brownout_irq, brownout_status}));
        chk("brownout no reset", 32'(pmrs_pkg::PMRS_RUN), 32'(mode));
        pins.brownout_stage1 = 1'b0;
        cycles(4);
        chk("brownout clear", 32'h0, 32'({brownout_irq, brownout_status}));
        $display("test brownout done");
        stop_test();
    end
endmodule
